//--- design/ram_bist_loopback_pkg.sv
// Package: register map, field layout and state codes of the self-test control block
package ram_bist_loopback_pkg;

	// ----------------------------------------------------------------
	// Register map (host register address space)
	// ----------------------------------------------------------------
	localparam int          REG_ADDR_W        = 8;
	localparam logic [7:0]  BIST_FAIL_ADDR_OFS = 8'h1B;
	localparam logic [7:0]  SELF_TEST_CTRL_OFS = 8'h28;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int          CTRL_ENABLE_BIT   = 15;
	localparam int          CTRL_SEL_LSB      = 11;
	localparam int          CTRL_SEL_W        = 3;
	localparam int          CTRL_LAUNCH_BIT   = 10;
	localparam int          CTRL_PASS_BIT     = 9;
	localparam int          CTRL_FAIL_BIT     = 8;
	localparam int          CTRL_ANALOG_BIT   = 5;
	localparam int          CTRL_SYNC_BIT     = 4;
	localparam int          CTRL_BUSSEL_BIT   = 3;
	localparam int          CTRL_LBLAUNCH_BIT = 2;
	localparam int          CTRL_LBPASS_BIT   = 1;
	localparam int          CTRL_LBFAIL_BIT   = 0;

	// ----------------------------------------------------------------
	// RAM test geometry and reset values
	// ----------------------------------------------------------------
	localparam int          QUAD_COUNT        = 4;
	localparam int          OFS_W             = 13;
	localparam logic [12:0] OFS_LAST          = 13'h1FFF;
	localparam logic [15:0] QUAD_STRIDE       = 16'h2000;
	localparam logic [15:0] FAIL_ADDR_RESET   = 16'h0000;
	localparam logic [15:0] WORD_ZERO         = 16'h0000;
	localparam logic [2:0]  SYNC_RESET        = 3'h0;

	// ----------------------------------------------------------------
	// RAM test sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		BIST_IDLE  = 4'b0001,
		BIST_FILL  = 4'b0010,
		BIST_READ  = 4'b0100,
		BIST_CHECK = 4'b1000
	} bist_state_t;

endpackage : ram_bist_loopback_pkg

//--- design/ram_bist_loopback_test_ctrl.sv
// Self-test control: RAM self-test sequencer, failing address capture, loopback setup
`timescale 1ns/1ns
// Operation
// [R1] Clean RAM test end sets pass flag
// [R2] Accepted launch clears pass and fail flags
// [R3] Any error during RAM test sets fail
// [R4] Four quadrants tested together, one shared offset
// [R5] Failing lowest-quadrant address held for host read
// [R6] Fault lies at address plus quadrant strides
// [R7] Test-mode low: location returns message info word
// [R8] Bits seven and six read zero always
// [R9] Analog low: digital loopback, bus undriven
// [R10] Analog high: test word driven onto bus
// [R11] Sync high: command sync precedes test word
// [R12] Sync low: data sync precedes test word
// [R13] Launch starts selected test, self-clears at end
// [R14] Launch needs test-mode high, enable already set
// [R15] Loopback launch starts test, self-clears on completion
// [R16] Pass and fail hold until next launch
module ram_bist_loopback_test_ctrl (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Test-mode pin (asynchronous)
	input  wire logic        testModePin,
	// Register access from the host serial port decoder
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	input  wire logic [7:0]  regAddr,
	input  wire logic [15:0] regWrData,
	output logic      [15:0] regRdData,
	output logic             regRdValid,
	// Normal-mode word shown at the failing address location
	input  wire logic [15:0] msgInfoWord,
	// Four-lane RAM test port, lane i sits at offset plus i quadrant strides
	output logic      [12:0] ramTestOfs,
	output logic             ramTestWe,
	output logic             ramTestRe,
	output logic      [15:0] ramTestWrData,
	input  wire logic [63:0] ramTestRdData,
	// Loopback engine
	output logic             lbRun,
	output logic             lbDriveBus,
	output logic             lbCmdSync,
	output logic             lbBusB,
	input  wire logic        lbDone,
	input  wire logic        lbResultPass
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		ram_bist_loopback_pkg::bist_state_t st;
		logic [12:0] ofs;
		logic        enable;
		logic [2:0]  sel;
		logic        launch;
		logic        pass;
		logic        fail;
		logic [15:0] failAddr;
		logic        analog;
		logic        sync;
		logic        busSel;
		logic        lbLaunch;
		logic        lbPass;
		logic        lbFail;
		logic [2:0]  tmSync;
		logic        testMode;
		logic [15:0] rdData;
		logic        rdValid;
	} state_t;

	state_t s_q;
	state_t s_d;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Test word per pattern select; alternating bits catch adjacent shorts
	function automatic logic [15:0] patternFor(input logic [2:0] sel);
		unique case (sel)
			3'h0:    patternFor = 16'h0000;
			3'h1:    patternFor = 16'h5555;
			3'h2:    patternFor = 16'hAAAA;
			3'h3:    patternFor = 16'h3333;
			3'h4:    patternFor = 16'h0F0F;
			3'h5:    patternFor = 16'h00FF;
			3'h6:    patternFor = 16'hF0F0;
			default: patternFor = 16'hFFFF;
		endcase
	endfunction : patternFor

	function automatic logic [15:0] ctrlWord(input state_t s);
		ctrlWord = ram_bist_loopback_pkg::WORD_ZERO;
		ctrlWord[ram_bist_loopback_pkg::CTRL_ENABLE_BIT]   = s.enable;
		ctrlWord[ram_bist_loopback_pkg::CTRL_SEL_LSB +: 3] = s.sel;
		ctrlWord[ram_bist_loopback_pkg::CTRL_LAUNCH_BIT]   = s.launch;
		ctrlWord[ram_bist_loopback_pkg::CTRL_PASS_BIT]     = s.pass;
		ctrlWord[ram_bist_loopback_pkg::CTRL_FAIL_BIT]     = s.fail;
		ctrlWord[ram_bist_loopback_pkg::CTRL_ANALOG_BIT]   = s.analog;
		ctrlWord[ram_bist_loopback_pkg::CTRL_SYNC_BIT]     = s.sync;
		ctrlWord[ram_bist_loopback_pkg::CTRL_BUSSEL_BIT]   = s.busSel;
		ctrlWord[ram_bist_loopback_pkg::CTRL_LBLAUNCH_BIT] = s.lbLaunch;
		ctrlWord[ram_bist_loopback_pkg::CTRL_LBPASS_BIT]   = s.lbPass;
		ctrlWord[ram_bist_loopback_pkg::CTRL_LBFAIL_BIT]   = s.lbFail;
	endfunction : ctrlWord

	logic        ctrlWr;
	logic        launchOk;
	logic        lbLaunchOk;
	logic        mismatch;
	logic [15:0] expectWord;

	assign ctrlWr     = regWrEn && (regAddr == ram_bist_loopback_pkg::SELF_TEST_CTRL_OFS);
	assign expectWord = patternFor(s_q.sel);
	// Launch honoured only with test mode and the enable bit set before this write
	assign launchOk   = ctrlWr && regWrData[ram_bist_loopback_pkg::CTRL_LAUNCH_BIT]
		&& s_q.testMode && s_q.enable && (s_q.st == ram_bist_loopback_pkg::BIST_IDLE); // [R14]
	assign lbLaunchOk = ctrlWr && regWrData[ram_bist_loopback_pkg::CTRL_LBLAUNCH_BIT]
		&& s_q.testMode && !s_q.lbLaunch;

	always_comb
	begin
		mismatch = 1'b0;
		for (int i = 0; i < ram_bist_loopback_pkg::QUAD_COUNT; i++)
		begin
			if (ramTestRdData[16*i +: 16] != expectWord)
			begin
				mismatch = 1'b1; // [R4]
			end
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q; // [R16]
		s_d.tmSync = {s_q.tmSync[1:0], testModePin};
		// A pin change counts once the second and third stages agree
		if (s_q.tmSync[1] == s_q.tmSync[2])
		begin
			s_d.testMode = s_q.tmSync[2];
		end

		if (ctrlWr)
		begin
			s_d.enable = regWrData[ram_bist_loopback_pkg::CTRL_ENABLE_BIT];
			s_d.analog = regWrData[ram_bist_loopback_pkg::CTRL_ANALOG_BIT];
			s_d.sync   = regWrData[ram_bist_loopback_pkg::CTRL_SYNC_BIT];
			s_d.busSel = regWrData[ram_bist_loopback_pkg::CTRL_BUSSEL_BIT];
			// Changing the pattern mid-test would corrupt the compare
			if (s_q.st == ram_bist_loopback_pkg::BIST_IDLE)
			begin
				s_d.sel = regWrData[ram_bist_loopback_pkg::CTRL_SEL_LSB +: 3];
			end
		end

		// RAM self-test sequencer
		unique case (s_q.st)
			ram_bist_loopback_pkg::BIST_IDLE:
			begin
				if (launchOk)
				begin
					s_d.launch = 1'b1; // [R13]
					s_d.pass   = 1'b0; // [R2]
					s_d.fail   = 1'b0; // [R2]
					s_d.ofs    = '0;
					s_d.st     = ram_bist_loopback_pkg::BIST_FILL;
				end
			end
			ram_bist_loopback_pkg::BIST_FILL:
			begin
				s_d.ofs = s_q.ofs + 13'h0001; // [R4]
				if (s_q.ofs == ram_bist_loopback_pkg::OFS_LAST)
				begin
					s_d.st = ram_bist_loopback_pkg::BIST_READ;
				end
			end
			ram_bist_loopback_pkg::BIST_READ:
			begin
				s_d.st = ram_bist_loopback_pkg::BIST_CHECK;
			end
			ram_bist_loopback_pkg::BIST_CHECK:
			begin
				if (mismatch)
				begin
					s_d.fail     = 1'b1; // [R3]
					// Lowest-quadrant address; the fault may sit one to three strides higher
					s_d.failAddr = {3'h0, s_q.ofs}; // [R5] [R6]
					s_d.launch   = 1'b0; // [R13]
					s_d.st       = ram_bist_loopback_pkg::BIST_IDLE;
				end
				else if (s_q.ofs == ram_bist_loopback_pkg::OFS_LAST)
				begin
					s_d.pass   = 1'b1; // [R1]
					s_d.launch = 1'b0; // [R13]
					s_d.st     = ram_bist_loopback_pkg::BIST_IDLE;
				end
				else
				begin
					s_d.ofs = s_q.ofs + 13'h0001;
					s_d.st  = ram_bist_loopback_pkg::BIST_READ;
				end
			end
			default:
			begin
				s_d.st = ram_bist_loopback_pkg::BIST_IDLE;
			end
		endcase

		// Loopback launch and self-clear
		if (lbLaunchOk)
		begin
			s_d.lbLaunch = 1'b1; // [R15]
			s_d.lbPass   = 1'b0;
			s_d.lbFail   = 1'b0;
		end
		else if (s_q.lbLaunch && lbDone)
		begin
			s_d.lbLaunch = 1'b0; // [R15]
			s_d.lbPass   = lbResultPass;
			s_d.lbFail   = !lbResultPass;
		end

		// Register read
		s_d.rdValid = regRdEn;
		if (regRdEn)
		begin
			if (regAddr == ram_bist_loopback_pkg::BIST_FAIL_ADDR_OFS)
			begin
				s_d.rdData = s_q.testMode ? s_q.failAddr : msgInfoWord; // [R5] [R7]
			end
			else if (regAddr == ram_bist_loopback_pkg::SELF_TEST_CTRL_OFS)
			begin
				s_d.rdData = ctrlWord(s_q); // [R8]
			end
			else
			begin
				s_d.rdData = ram_bist_loopback_pkg::WORD_ZERO;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			s_q          <= '0;
			s_q.st       <= ram_bist_loopback_pkg::BIST_IDLE;
			s_q.failAddr <= ram_bist_loopback_pkg::FAIL_ADDR_RESET;
			s_q.tmSync   <= ram_bist_loopback_pkg::SYNC_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign regRdData     = s_q.rdData;
	assign regRdValid    = s_q.rdValid;
	assign ramTestOfs    = s_q.ofs;
	assign ramTestWe     = (s_q.st == ram_bist_loopback_pkg::BIST_FILL);
	assign ramTestRe     = (s_q.st == ram_bist_loopback_pkg::BIST_READ);
	assign ramTestWrData = expectWord;
	assign lbRun         = s_q.lbLaunch;
	assign lbDriveBus    = s_q.lbLaunch && s_q.analog; // [R9] [R10]
	assign lbCmdSync     = s_q.sync; // [R11] [R12]
	assign lbBusB        = s_q.busSel;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	AST_PASS_ON_CLEAN_END: assert property ( // [R1]
		(s_q.st == ram_bist_loopback_pkg::BIST_CHECK) && !mismatch
		&& (s_q.ofs == ram_bist_loopback_pkg::OFS_LAST)
		|=> s_q.pass && !s_q.fail && !s_q.launch)
		else $error("pass flag not set at clean test end");
	AST_LAUNCH_CLEARS: assert property ( // [R2]
		launchOk |=> s_q.launch && !s_q.pass && !s_q.fail
		&& (s_q.st == ram_bist_loopback_pkg::BIST_FILL))
		else $error("launch did not clear flags");
	AST_FAIL_CAPTURE: assert property ( // [R3]
		(s_q.st == ram_bist_loopback_pkg::BIST_CHECK) && mismatch
		|=> s_q.fail && (s_q.failAddr == {3'h0, $past(s_q.ofs)}) && !s_q.launch)
		else $error("fail flag or address not captured");
	AST_FILL_STEPS: assert property ( // [R4]
		ramTestWe && (s_q.ofs != ram_bist_loopback_pkg::OFS_LAST)
		|=> ramTestOfs == $past(s_q.ofs) + 13'h0001)
		else $error("fill offset did not step by one");
	AST_FAIL_ADDR_READ: assert property ( // [R5]
		regRdEn && (regAddr == ram_bist_loopback_pkg::BIST_FAIL_ADDR_OFS) && s_q.testMode
		|=> regRdValid && (regRdData == $past(s_q.failAddr)))
		else $error("failing address read wrong");
	AST_INFO_READ: assert property ( // [R7]
		regRdEn && (regAddr == ram_bist_loopback_pkg::BIST_FAIL_ADDR_OFS) && !s_q.testMode
		|=> regRdData == $past(msgInfoWord))
		else $error("message info word not returned");
	AST_RESERVED_ZERO: assert property ( // [R8]
		regRdEn && (regAddr == ram_bist_loopback_pkg::SELF_TEST_CTRL_OFS)
		|=> regRdData[7:6] == 2'h0)
		else $error("unused bits read nonzero");
	AST_LAUNCH_GATED: assert property ( // [R14]
		ctrlWr && regWrData[ram_bist_loopback_pkg::CTRL_LAUNCH_BIT] && !s_q.launch
		&& (!s_q.testMode || !s_q.enable) |=> !s_q.launch)
		else $error("launch taken without test mode and enable");
	AST_BUS_DRIVE: assert property ( // [R9]
		lbLaunchOk && !regWrData[ram_bist_loopback_pkg::CTRL_ANALOG_BIT]
		|=> lbRun && !lbDriveBus)
		else $error("bus driven in digital loopback");
	AST_ANALOG_DRIVE: assert property ( // [R10]
		lbLaunchOk && regWrData[ram_bist_loopback_pkg::CTRL_ANALOG_BIT] |=> lbDriveBus)
		else $error("analog loopback did not drive bus");
	AST_SYNC_TYPE: assert property ( // [R11] [R12]
		ctrlWr |=> lbCmdSync == $past(regWrData[ram_bist_loopback_pkg::CTRL_SYNC_BIT]))
		else $error("sync type does not follow control bit");
	AST_LB_SELF_CLEAR: assert property ( // [R15]
		s_q.lbLaunch && lbDone |=> !lbRun && (s_q.lbPass == $past(lbResultPass)))
		else $error("loopback launch not cleared on completion");
	AST_FLAGS_HOLD: assert property ( // [R16]
		(s_q.st == ram_bist_loopback_pkg::BIST_IDLE) && !launchOk
		|=> $stable(s_q.pass) && $stable(s_q.fail))
		else $error("result flags changed while idle");
	COV_PASS: cover property ($rose(s_q.pass));
	COV_FAIL: cover property ($rose(s_q.fail));
	COV_LOOPBACK: cover property (lbLaunchOk ##[1:50] (s_q.lbLaunch && lbDone));
	COV_INFO_READ: cover property (regRdEn && !s_q.testMode
		&& (regAddr == ram_bist_loopback_pkg::BIST_FAIL_ADDR_OFS));

endmodule : ram_bist_loopback_test_ctrl

//--- verif/ram_lb_partner.sv
// Far-side model: four-lane test RAM with one bit inverted on read, and a loopback engine
`timescale 1ns/1ns
module ram_lb_partner (
	// Clock
	input  wire logic        ref_clk,
	// RAM test port
	input  wire logic [12:0] ramTestOfs,
	input  wire logic        ramTestWe,
	input  wire logic        ramTestRe,
	input  wire logic [15:0] ramTestWrData,
	output logic      [63:0] ramTestRdData,
	// Loopback engine
	input  wire logic        lbRun,
	output logic             lbDone,
	output logic             lbResultPass,
	// Scenario control
	input  wire logic        faultEn,
	input  wire logic [14:0] faultAddr,
	input  wire logic [7:0]  lbDelay,
	input  wire logic        lbPass
);
	logic [15:0] mem [0:32767];
	logic [63:0] rdQ;
	logic        rdVal;
	int          cnt;

	function automatic logic [15:0] flip(input logic [14:0] a);
		return {15'h0, faultEn && a == faultAddr};
	endfunction : flip

	// Lane i sits i quadrant strides above the shared offset
	always_ff @(posedge ref_clk)
	begin
		rdVal <= ramTestRe;
		for (int i = 0; i < 4; i++)
		begin
			if (ramTestWe)
				mem[{i[1:0], ramTestOfs}] <= ramTestWrData;
			if (ramTestRe)
				rdQ[16*i+:16] <= mem[{i[1:0], ramTestOfs}] ^ flip({i[1:0], ramTestOfs});
		end
	end
	// Data is only valid one cycle after the request; stale data is inverted
	assign ramTestRdData = rdVal ? rdQ : ~rdQ;

	// One completion pulse a set time after the run starts
	always_ff @(posedge ref_clk)
	begin
		lbDone <= 1'b0;
		if (!lbRun)
			cnt <= 0;
		else if (cnt <= int'(lbDelay))
		begin
			cnt <= cnt + 1;
			lbDone <= (cnt == int'(lbDelay));
		end
	end
	assign lbResultPass = lbDone ? lbPass : ~lbPass;
endmodule : ram_lb_partner

//--- verif/ram_bist_loopback_test_ctrl_tb.sv
// Self-checking bench of the self-test control block
`timescale 1ns/1ns
module ram_bist_loopback_test_ctrl_tb;
	localparam logic [7:0] CTRL_A = ram_bist_loopback_pkg::SELF_TEST_CTRL_OFS;
	localparam logic [7:0] FAIL_A = ram_bist_loopback_pkg::BIST_FAIL_ADDR_OFS;
	// Fill word per pattern select, lowest slice is select zero
	localparam logic [127:0] PATS = {16'hFFFF, 16'hF0F0, 16'h00FF, 16'h0F0F,
		16'h3333, 16'hAAAA, 16'h5555, 16'h0000};
	logic        ref_clk;
	logic        resetn;
	logic        testModePin;
	logic        regWrEn;
	logic        regRdEn;
	logic [7:0]  regAddr;
	logic [15:0] regWrData;
	logic [15:0] regRdData;
	logic        regRdValid;
	logic [15:0] msgInfoWord;
	logic [12:0] ramTestOfs;
	logic        ramTestWe;
	logic        ramTestRe;
	logic [15:0] ramTestWrData;
	logic [63:0] ramTestRdData;
	logic        lbRun;
	logic        lbDriveBus;
	logic        lbCmdSync;
	logic        lbBusB;
	logic        lbDone;
	logic        lbResultPass;
	logic        faultEn;
	logic [14:0] faultAddr;
	logic [7:0]  lbDelay;
	logic        lbPass;
	logic [31:0] seed = 32'hE1F142E7;
	logic [15:0] rdWord;
	int          failures = 0;
	int          totalChecks = 0;

	ram_bist_loopback_test_ctrl dut_u (.ref_clk(ref_clk), .resetn(resetn),
		.testModePin(testModePin), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid), .msgInfoWord(msgInfoWord), .ramTestOfs(ramTestOfs),
		.ramTestWe(ramTestWe), .ramTestRe(ramTestRe), .ramTestWrData(ramTestWrData),
		.ramTestRdData(ramTestRdData), .lbRun(lbRun), .lbDriveBus(lbDriveBus),
		.lbCmdSync(lbCmdSync), .lbBusB(lbBusB), .lbDone(lbDone),
		.lbResultPass(lbResultPass));
	ram_lb_partner far_u (.ref_clk(ref_clk), .ramTestOfs(ramTestOfs),
		.ramTestWe(ramTestWe), .ramTestRe(ramTestRe), .ramTestWrData(ramTestWrData),
		.ramTestRdData(ramTestRdData), .lbRun(lbRun), .lbDone(lbDone),
		.lbResultPass(lbResultPass), .faultEn(faultEn), .faultAddr(faultAddr),
		.lbDelay(lbDelay), .lbPass(lbPass));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xorshift

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		totalChecks++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wrReg(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		#1 regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(posedge ref_clk);
		#1 regWrEn = 1'b0;
	endtask : wrReg

	task automatic rdReg(input logic [7:0] a);
		@(posedge ref_clk);
		#1 regRdEn = 1'b1;
		regAddr = a;
		@(posedge ref_clk);
		#1 regRdEn = 1'b0;
		check({15'h0, regRdValid}, 16'h0001);
		rdWord = regRdData;
	endtask : rdReg

	// Polling is bounded so a launch bit that never clears cannot hang the run
	task automatic waitClear(input int bitPos);
		int n;
		n = 0;
		do
		begin
			rdReg(CTRL_A);
			n++;
		end
		while (rdWord[bitPos] === 1'b1 && n < 20000);
	endtask : waitClear

	task automatic end_sim();
		if (failures == 0 && totalChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// Clock, watchdog and scenarios
	// ----------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	initial
	begin
		#400000;
		failures++;
		end_sim();
	end

	initial
	begin
		logic [31:0] r;
		logic [15:0] base;
		resetn = 1'b0;
		testModePin = 1'b0;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 16'h0000;
		msgInfoWord = 16'h3C5A;
		faultEn = 1'b0;
		faultAddr = 15'h0000;
		lbDelay = 8'h02;
		lbPass = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1 resetn = 1'b1;
		rdReg(FAIL_A);
		check(rdWord, msgInfoWord);
		rdReg(8'h55);
		check(rdWord, 16'h0000);
		testModePin = 1'b1;
		repeat (6) @(posedge ref_clk);
		// Launch in the same write as enable must be refused
		wrReg(CTRL_A, 16'h84C0);
		rdReg(CTRL_A);
		check(rdWord, 16'h8000);
		for (int run = 0; run < 2; run++)
		begin
			r = xorshift();
			faultEn = run[0];
			faultAddr = r[30:16];
			base = {2'b10, r[2:0], 11'h000};
			wrReg(CTRL_A, base);
			wrReg(CTRL_A, base | 16'h0400);
			rdReg(CTRL_A);
			check(rdWord, base | 16'h0400);
			check(ramTestWrData, PATS[16*r[2:0] +: 16]);
			check({15'h0, ramTestWe}, 16'h0001);
			waitClear(ram_bist_loopback_pkg::CTRL_LAUNCH_BIT);
			check(rdWord, base | (run[0] ? 16'h0100 : 16'h0200));
		end
		rdReg(FAIL_A);
		check(rdWord, {3'b000, faultAddr[12:0]});
		for (int i = 0; i < 4; i++)
		begin
			r = xorshift();
			lbDelay = 8'd2 + {5'd0, r[2:0]};
			lbPass = r[3];
			wrReg(CTRL_A, base | {10'h0, i[0], i[1], r[4], 3'b100});
			@(posedge ref_clk);
			#1;
			check({12'h0, lbRun, lbDriveBus, lbCmdSync, lbBusB},
				{12'h0, 1'b1, i[0], i[1], r[4]});
			waitClear(ram_bist_loopback_pkg::CTRL_LBLAUNCH_BIT);
			check({10'h0, rdWord[5:0]}, {10'h0, i[0], i[1], r[4], 1'b0, r[3], ~r[3]});
			check({15'h0, lbDriveBus}, 16'h0000);
		end
		testModePin = 1'b0;
		msgInfoWord = 16'hA5C3;
		repeat (6) @(posedge ref_clk);
		#1;
		wrReg(CTRL_A, base | 16'h0404);
		rdReg(CTRL_A);
		check({14'h0, rdWord[10], rdWord[2]}, 16'h0000);
		check({15'h0, rdWord[8]}, 16'h0001);
		rdReg(FAIL_A);
		check(rdWord, msgInfoWord);
		// Master reset while idle must drop the held result flags
		resetn = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1 resetn = 1'b1;
		rdReg(CTRL_A);
		check(rdWord, 16'h0000);
		end_sim();
	end
endmodule : ram_bist_loopback_test_ctrl_tb
